// [core/step_seq_regs.vh]
`ifndef STEP_SEQ_REGS_VH
`define STEP_SEQ_REGS_VH
// avalon register byte addresses
`define ADDR_CONTROL 4'h0
`define ADDR_VELOCITY 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_POSITION 4'hC
// control register fields
`define CTL_BOTH_EDGES 0
`define CTL_SERIAL_CFG 1
`define CTL_GENERATOR 2
`define CTL_BIDIR 3
`define CTL_RES_LSB 4
`define CTL_RES_MSB 7
`define CTL_ADDR_LSB 8
`define CTL_ADDR_MSB 9
`define CONTROL_RESET 32'h00000000
// resolution codes: 0 = 1/256 ... 8 = fullstep
`define RES_256 4'h0
`define RES_64 4'h2
`define RES_32 4'h3
`define RES_16 4'h4
`define RES_8 4'h5
`define RES_FULL 4'h8
// mode pin codes
`define MODE_SERIAL 2'h2
`define MODE_STANDALONE 2'h3
// serial baud window in clock cycles at 100 MHz (9600 .. 500k baud)
`define BAUD_MIN_CYCLES 16'h00C8
`define BAUD_MAX_CYCLES 16'h28B1
`define POS_RESET 10'h000
`endif

// [core/sine_lut.v]
`timescale 1ns/1ps
// quarter-wave sine table: 256 entries of one quadrant, 8-bit magnitude
module sine_lut (
	// phase in, one electrical period in 1024 steps
	input wire [9:0] phase_in,
	// signed current target
	output reg signed [8:0] value_out
);
	reg [7:0] idx;
	reg [7:0] mag;
	integer i;
	integer level;
	reg [7:0] table_mem [0:255];
	// table filled from the sine function at start-up; the half-step offset keeps both halves symmetric
	initial begin
		for (i = 0; i < 256; i = i + 1) begin
			level = $rtoi(255.0 * $sin(3.14159265 * (i + 0.5) / 512.0) + 0.5);
			table_mem[i] = level[7:0];
		end
	end
	always @* begin
		idx = phase_in[8] ? ~phase_in[7:0] : phase_in[7:0];
		mag = table_mem[idx];
		value_out = phase_in[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	end
endmodule

// [core/step_dir_microstep_sequencer.v]
`timescale 1ns/1ps
`include "step_seq_regs.vh"
module step_dir_microstep_sequencer (
	// clock and reset
	input wire MCLK_IN,
	input wire RST_N_IN,
	// avalon-mm slave
	input wire [3:0] AVS_ADDRESS_IN,
	input wire AVS_READ_IN,
	input wire AVS_WRITE_IN,
	input wire [31:0] AVS_WRITEDATA_IN,
	input wire [3:0] AVS_BYTEENABLE_IN,
	output reg [31:0] AVS_READDATA_OUT,
	output reg AVS_WAITREQUEST_OUT,
	// motion pins
	input wire STEP_IN,
	input wire DIR_IN,
	input wire RESOLUTION_SELECT_LO_IN,
	input wire RESOLUTION_SELECT_HI_IN,
	input wire [1:0] MODE_SELECT_IN,
	input wire ENABLE_INVERTED_IN,
	input wire DRIVER_FAULT_IN,
	// powerdown serial pin, three-signal form
	input wire POWERDOWN_SERIAL_PIN_IN,
	output reg POWERDOWN_SERIAL_PIN_OUT,
	output reg POWERDOWN_SERIAL_PIN_OE_OUT,
	// coil targets and status
	output reg signed [8:0] COIL_A_TARGET_OUT,
	output reg signed [8:0] COIL_B_TARGET_OUT,
	output reg [9:0] MICROSTEP_POSITION_OUT,
	output reg POWER_STAGE_ON_OUT,
	output reg STANDSTILL_REDUCTION_OUT,
	output reg DIAGNOSTIC_OUTPUT_OUT,
	output reg INDEX_OUT,
	output reg [1:0] SERIAL_ADDRESS_OUT,
	output reg [15:0] BAUD_CYCLES_OUT,
	output reg BAUD_LOCKED_OUT
);
	reg [31:0] control_reg;
	reg [31:0] velocity_reg;
	reg [9:0] pos_reg;
	reg [9:0] pos_next;
	reg step_s1_reg, step_s2_reg, step_s3_reg;
	reg dir_s1_reg, dir_s2_reg;
	reg rx_s1_reg, rx_s2_reg, rx_s3_reg;
	reg [31:0] accum_reg;
	reg fault_latch_reg;
	reg standalone_reg;
	reg [15:0] bit_count_reg;
	reg [1:0] baud_state_reg;
	reg [3:0] res_code;
	reg [9:0] step_inc;
	reg pin_step, gen_step, step_dir;
	reg [32:0] accum_sum;
	wire signed [8:0] sin_val;
	wire signed [8:0] cos_val;
	wire bus_hit;
	wire [9:0] cos_phase;
	localparam BAUD_IDLE = 2'b01;
	localparam BAUD_MEASURE = 2'b10;

	// bus answers in the cycle after a request; a single wait cycle keeps readdata registered
	assign bus_hit = (AVS_READ_IN | AVS_WRITE_IN) & AVS_WAITREQUEST_OUT;
	assign cos_phase = pos_reg + 10'h100;

	sine_lut lut_a (
		.phase_in(pos_reg),
		.value_out(sin_val)
	);
	sine_lut lut_b (
		.phase_in(cos_phase),
		.value_out(cos_val)
	);

	// resolution: pin decode in standalone or with the serial-config bit clear, register otherwise
	always @* begin
		if (standalone_reg || !control_reg[`CTL_SERIAL_CFG]) begin
			case ({RESOLUTION_SELECT_HI_IN, RESOLUTION_SELECT_LO_IN})
				2'b00: res_code = `RES_8;
				2'b01: res_code = `RES_32;
				2'b10: res_code = `RES_64;
				default: res_code = `RES_16;
			endcase
		end else if (control_reg[`CTL_RES_MSB:`CTL_RES_LSB] > `RES_FULL) begin
			res_code = `RES_FULL;
		end else begin
			res_code = control_reg[`CTL_RES_MSB:`CTL_RES_LSB];
		end
		step_inc = 10'h001 << res_code;
	end

	// step event selection and counter update
	always @* begin
		pin_step = control_reg[`CTL_BOTH_EDGES] ? (step_s2_reg ^ step_s3_reg)
			: (step_s2_reg & ~step_s3_reg);
		accum_sum = {1'b0, accum_reg} + {1'b0, velocity_reg[31] ? -velocity_reg : velocity_reg};
		gen_step = control_reg[`CTL_GENERATOR] && !standalone_reg && accum_sum[32];
		step_dir = control_reg[`CTL_GENERATOR] && !standalone_reg ? velocity_reg[31] : dir_s2_reg;
		pos_next = pos_reg;
		if (pin_step || gen_step) begin
			// 10-bit arithmetic wraps naturally at 1024
			pos_next = step_dir ? pos_reg - step_inc : pos_reg + step_inc;
		end
	end

	// synchronisers: stage one feeds stage two only
	always @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			step_s1_reg <= 1'b0;
			step_s2_reg <= 1'b0;
			step_s3_reg <= 1'b0;
			dir_s1_reg <= 1'b0;
			dir_s2_reg <= 1'b0;
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_s3_reg <= 1'b1;
		end else begin
			step_s1_reg <= STEP_IN;
			step_s2_reg <= step_s1_reg;
			step_s3_reg <= step_s2_reg;
			dir_s1_reg <= DIR_IN;
			dir_s2_reg <= dir_s1_reg;
			rx_s1_reg <= POWERDOWN_SERIAL_PIN_IN;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
		end
	end

	// avalon slave: one wait cycle, unmapped reads return zero, writes there are dropped
	always @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			control_reg <= `CONTROL_RESET;
			velocity_reg <= 32'h00000000;
			AVS_READDATA_OUT <= 32'h00000000;
			AVS_WAITREQUEST_OUT <= 1'b1;
		end else begin
			AVS_WAITREQUEST_OUT <= ~bus_hit;
			if (bus_hit && AVS_WRITE_IN) begin
				case (AVS_ADDRESS_IN)
					`ADDR_CONTROL: begin
						if (AVS_BYTEENABLE_IN[0]) control_reg[7:0] <= AVS_WRITEDATA_IN[7:0];
						if (AVS_BYTEENABLE_IN[1]) control_reg[15:8] <= AVS_WRITEDATA_IN[15:8];
					end
					`ADDR_VELOCITY: begin
						if (AVS_BYTEENABLE_IN[0]) velocity_reg[7:0] <= AVS_WRITEDATA_IN[7:0];
						if (AVS_BYTEENABLE_IN[1]) velocity_reg[15:8] <= AVS_WRITEDATA_IN[15:8];
						if (AVS_BYTEENABLE_IN[2]) velocity_reg[23:16] <= AVS_WRITEDATA_IN[23:16];
						if (AVS_BYTEENABLE_IN[3]) velocity_reg[31:24] <= AVS_WRITEDATA_IN[31:24];
					end
					default: begin
						control_reg <= control_reg;
					end
				endcase
			end
			if (bus_hit && AVS_READ_IN) begin
				case (AVS_ADDRESS_IN)
					`ADDR_CONTROL: AVS_READDATA_OUT <= {22'h000000, control_reg[9:0]};
					`ADDR_VELOCITY: AVS_READDATA_OUT <= velocity_reg;
					`ADDR_STATUS: AVS_READDATA_OUT <= {BAUD_CYCLES_OUT, 10'h000, BAUD_LOCKED_OUT,
						standalone_reg, fault_latch_reg, SERIAL_ADDRESS_OUT, POWER_STAGE_ON_OUT};
					`ADDR_POSITION: AVS_READDATA_OUT <= {22'h000000, pos_reg};
					default: AVS_READDATA_OUT <= 32'h00000000;
				endcase
			end else begin
				AVS_READDATA_OUT <= AVS_READDATA_OUT;
			end
		end
	end

	// sequencer, generator accumulator and derived outputs
	always @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			pos_reg <= `POS_RESET;
			accum_reg <= 32'h00000000;
			fault_latch_reg <= 1'b0;
			standalone_reg <= 1'b0;
			COIL_A_TARGET_OUT <= 9'h000;
			COIL_B_TARGET_OUT <= 9'h000;
			MICROSTEP_POSITION_OUT <= 10'h000;
			POWER_STAGE_ON_OUT <= 1'b0;
			STANDSTILL_REDUCTION_OUT <= 1'b0;
			DIAGNOSTIC_OUTPUT_OUT <= 1'b0;
			INDEX_OUT <= 1'b0;
			SERIAL_ADDRESS_OUT <= 2'h0;
			POWERDOWN_SERIAL_PIN_OUT <= 1'b1;
			POWERDOWN_SERIAL_PIN_OE_OUT <= 1'b0;
		end else begin
			standalone_reg <= (MODE_SELECT_IN == `MODE_STANDALONE);
			pos_reg <= pos_next;
			// no ramp: the velocity acts at once on the step rate
			accum_reg <= (control_reg[`CTL_GENERATOR] && !standalone_reg) ? accum_sum[31:0] : 32'h00000000;
			COIL_A_TARGET_OUT <= sin_val;
			COIL_B_TARGET_OUT <= cos_val;
			MICROSTEP_POSITION_OUT <= pos_reg;
			// unused mode codes keep the power stage off as well
			POWER_STAGE_ON_OUT <= ENABLE_INVERTED_IN && MODE_SELECT_IN[1];
			// fault set yields to nothing but enable low, which clears latched errors
			if (!ENABLE_INVERTED_IN) begin
				fault_latch_reg <= 1'b0;
			end else if (DRIVER_FAULT_IN) begin
				fault_latch_reg <= 1'b1;
			end
			DIAGNOSTIC_OUTPUT_OUT <= fault_latch_reg && ENABLE_INVERTED_IN;
			// pin low means reduction active
			STANDSTILL_REDUCTION_OUT <= standalone_reg ? ~rx_s2_reg : 1'b1;
			INDEX_OUT <= (pos_reg == 10'h000);
			SERIAL_ADDRESS_OUT <= {RESOLUTION_SELECT_HI_IN, RESOLUTION_SELECT_LO_IN};
			// the reply path is not built here; the pin stays released, idle high
			POWERDOWN_SERIAL_PIN_OUT <= 1'b1;
			POWERDOWN_SERIAL_PIN_OE_OUT <= 1'b0;
		end
	end

	// baud detector: outside standalone mode, times every low pulse from its falling edge (such as the start bit of a sync byte)
	always @(posedge MCLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			baud_state_reg <= BAUD_IDLE;
			bit_count_reg <= 16'h0000;
			BAUD_CYCLES_OUT <= 16'h0000;
			BAUD_LOCKED_OUT <= 1'b0;
		end else begin
			case (baud_state_reg)
				BAUD_IDLE: begin
					bit_count_reg <= 16'h0000;
					if (!standalone_reg && rx_s3_reg && !rx_s2_reg) begin
						baud_state_reg <= BAUD_MEASURE;
					end
				end
				BAUD_MEASURE: begin
					if (rx_s2_reg) begin
						baud_state_reg <= BAUD_IDLE;
						// pulses outside the window are glitches or idle and are ignored
						if (bit_count_reg >= `BAUD_MIN_CYCLES && bit_count_reg <= `BAUD_MAX_CYCLES) begin
							BAUD_CYCLES_OUT <= bit_count_reg;
							BAUD_LOCKED_OUT <= 1'b1;
						end
					end else if (bit_count_reg == 16'hFFFF) begin
						baud_state_reg <= BAUD_IDLE;
					end else begin
						bit_count_reg <= bit_count_reg + 16'h0001;
					end
				end
				default: baud_state_reg <= BAUD_IDLE;
			endcase
		end
	end
endmodule

// [dv/seq_monitor.sv]
`timescale 1ns/1ps
// pin decode, fault latch and bus handshake checks
module seq_monitor (
	// clock and reset
	input wire MCLK_IN,
	input wire RST_N_IN,
	// watched ports
	input wire AVS_READ_IN,
	input wire AVS_WRITE_IN,
	input wire AVS_WAITREQUEST_OUT,
	input wire RESOLUTION_SELECT_LO_IN,
	input wire RESOLUTION_SELECT_HI_IN,
	input wire [1:0] MODE_SELECT_IN,
	input wire ENABLE_INVERTED_IN,
	input wire DRIVER_FAULT_IN,
	input wire POWERDOWN_SERIAL_PIN_IN,
	input wire POWER_STAGE_ON_OUT,
	input wire STANDSTILL_REDUCTION_OUT,
	input wire DIAGNOSTIC_OUTPUT_OUT,
	input wire [1:0] SERIAL_ADDRESS_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// first edge after reset still sees the reset values, hence the past-reset guard
	AST_ADDR_PINS: assert property ($past(RST_N_IN) |->
		SERIAL_ADDRESS_OUT == $past({RESOLUTION_SELECT_HI_IN, RESOLUTION_SELECT_LO_IN})) else $error("address pins");
	AST_POWER: assert property ($past(RST_N_IN) |->
		POWER_STAGE_ON_OUT == $past(ENABLE_INVERTED_IN & MODE_SELECT_IN[1])) else $error("power stage");
	// mode is registered once and the pin passes two synchroniser stages before the output flop
	AST_STANDSTILL: assert property ($past(RST_N_IN, 3) && $past(MODE_SELECT_IN, 2) == 2'h3 |->
		STANDSTILL_REDUCTION_OUT == !$past(POWERDOWN_SERIAL_PIN_IN, 3)) else $error("standstill pin");
	AST_FLOAT: assert property (!ENABLE_INVERTED_IN |=> !POWER_STAGE_ON_OUT) else $error("stage on");
	AST_CLEAR: assert property (!ENABLE_INVERTED_IN |=> !DIAGNOSTIC_OUTPUT_OUT) else $error("diagnostic_output kept");
	// latch first, then the output flop: the fault shows two clocks after the event
	AST_LATCH: assert property (ENABLE_INVERTED_IN && DRIVER_FAULT_IN |-> ##2
		(DIAGNOSTIC_OUTPUT_OUT || !$past(ENABLE_INVERTED_IN))) else $error("fault latch");
	AST_ACK_ONE: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT) else $error("ack too long");
	AST_ACK_NEXT: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=>
		!AVS_WAITREQUEST_OUT) else $error("ack late");
endmodule
bind step_dir_microstep_sequencer seq_monitor mon (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
	.AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.RESOLUTION_SELECT_LO_IN(RESOLUTION_SELECT_LO_IN), .RESOLUTION_SELECT_HI_IN(RESOLUTION_SELECT_HI_IN),
	.MODE_SELECT_IN(MODE_SELECT_IN), .ENABLE_INVERTED_IN(ENABLE_INVERTED_IN), .DRIVER_FAULT_IN(DRIVER_FAULT_IN),
	.POWERDOWN_SERIAL_PIN_IN(POWERDOWN_SERIAL_PIN_IN), .POWER_STAGE_ON_OUT(POWER_STAGE_ON_OUT),
	.STANDSTILL_REDUCTION_OUT(STANDSTILL_REDUCTION_OUT), .DIAGNOSTIC_OUTPUT_OUT(DIAGNOSTIC_OUTPUT_OUT),
	.SERIAL_ADDRESS_OUT(SERIAL_ADDRESS_OUT));

// [dv/host_model.sv]
`timescale 1ns/1ps
// host side: step pulses and serial line activity
module host_model (
	input wire clk_in,
	output reg step_out,
	output reg dir_out,
	output reg serial_out
);
	initial begin
		step_out = 1'b0;
		dir_out = 1'b0;
		serial_out = 1'b1;
	end
	// direction settles three cycles before the edge so the synchroniser sees it first
	task step_pulse(input d, input b);
		begin
			@(posedge clk_in);
			dir_out <= d;
			repeat (3) @(posedge clk_in);
			step_out <= ~step_out;
			repeat (4) @(posedge clk_in);
			if (!b) begin
				step_out <= ~step_out;
				repeat (4) @(posedge clk_in);
			end
		end
	endtask
	// plain level on the line, held until changed again
	task hold_line(input v);
		begin
			@(posedge clk_in);
			serial_out <= v;
		end
	endtask
	// write-only use: one start bit of the chosen length, no reply awaited and so no checksum read
	task start_bit(input integer n);
		begin
			@(posedge clk_in);
			serial_out <= 1'b0;
			repeat (n) @(posedge clk_in);
			serial_out <= 1'b1;
		end
	endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/1ps
`include "step_seq_regs.vh"
module tb_top;
	// drive and observe
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg rd = 1'b0;
	reg wr = 1'b0;
	reg [3:0] adr = 4'h0;
	reg [31:0] wd = 32'h00000000;
	reg ms_lo = 1'b0;
	reg ms_hi = 1'b0;
	reg [1:0] mode = `MODE_SERIAL;
	reg en = 1'b1;
	reg flt = 1'b0;
	reg [31:0] q;
	wire [31:0] rdata;
	wire wreq, step, dir, ser, pd_o, pd_oe, idx, pwr, diagnostic_output, locked;
	wire [9:0] pos;
	wire [15:0] baud;
	wire sst;
	wire signed [8:0] ca, cb;
	wire line = pd_oe ? pd_o : ser;
	integer errors = 0;
	integer total_checks = 0;
	integer i;
	always #5 clk = ~clk;
	host_model host (.clk_in(clk), .step_out(step), .dir_out(dir), .serial_out(ser));
	step_dir_microstep_sequencer dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(adr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq), .STEP_IN(step), .DIR_IN(dir),
		.RESOLUTION_SELECT_LO_IN(ms_lo), .RESOLUTION_SELECT_HI_IN(ms_hi), .MODE_SELECT_IN(mode),
		.ENABLE_INVERTED_IN(en), .DRIVER_FAULT_IN(flt), .POWERDOWN_SERIAL_PIN_IN(line),
		.POWERDOWN_SERIAL_PIN_OUT(pd_o), .POWERDOWN_SERIAL_PIN_OE_OUT(pd_oe), .COIL_A_TARGET_OUT(ca),
		.COIL_B_TARGET_OUT(cb), .MICROSTEP_POSITION_OUT(pos), .POWER_STAGE_ON_OUT(pwr),
		.STANDSTILL_REDUCTION_OUT(sst), .DIAGNOSTIC_OUTPUT_OUT(diagnostic_output), .INDEX_OUT(idx),
		.SERIAL_ADDRESS_OUT(), .BAUD_CYCLES_OUT(baud), .BAUD_LOCKED_OUT(locked));
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("unexpected %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// request held until waitrequest is sampled low at a rising edge; data taken and request released there
	task bus(input w, input [3:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge clk);
			rd <= !w;
			wr <= w;
			adr <= a;
			wd <= d;
			n = 0;
			@(posedge clk);
			while (wreq !== 1'b0 && n < 100) begin
				@(posedge clk);
				n = n + 1;
			end
			if (wreq !== 1'b0) begin
				errors = errors + 1;
				$display("unexpected waitrequest expected 0 seen %b", wreq);
			end
			q = rdata;
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask
	// n steps in one direction, then the counter must have moved by n increments
	task mv(input d, input integer n, input [9:0] inc, input b);
		reg [9:0] p, e;
		begin
			p = pos;
			repeat (n) host.step_pulse(d, b);
			repeat (6) @(posedge clk);
			e = d ? p - n * inc : p + n * inc;
			chk("position", e, pos);
		end
	endtask
	task t_regs;
		begin
			bus(0, `ADDR_CONTROL, 0);
			chk("control", `CONTROL_RESET, q);
			bus(0, 4'h2, 0);
			chk("unmapped", 0, q);
			bus(0, `ADDR_STATUS, 0);
			chk("status", 5'h01, q[4:0]);
			chk("index", 1, idx);
			chk("standstill", 1, sst);
			chk("serial oe", 0, pd_oe);
			// at position zero the cosine coil is at its peak and the sine coil near zero
			chk("coil b", 9'h0FF, cb);
			chk("coil a", 1, ca >= -9'sd1 && ca <= 9'sd1);
		end
	endtask
	// register resolution: four fullsteps wrap back to zero, then every code once
	task t_reg_res;
		begin
			bus(1, `ADDR_CONTROL, 32'h00000082);
			mv(0, 4, 10'h100, 0);
			chk("index", 1, idx);
			for (i = 0; i <= 8; i = i + 1) begin
				bus(1, `ADDR_CONTROL, (i << 4) | 2);
				mv(0, 1, 10'h001 << i, 0);
			end
			chk("index", 0, idx);
			// codes above fullstep fall back to fullstep
			bus(1, `ADDR_CONTROL, 32'h00000092);
			mv(0, 1, 10'h100, 0);
		end
	endtask
	// pin resolution table; one reverse step checks the sampled direction
	task t_pins;
		reg [9:0] inc [0:3];
		begin
			inc[0] = 10'h020;
			inc[1] = 10'h008;
			inc[2] = 10'h004;
			inc[3] = 10'h010;
			bus(1, `ADDR_CONTROL, 0);
			for (i = 0; i < 4; i = i + 1) begin
				{ms_hi, ms_lo} <= i[1:0];
				mv(0, 2, inc[i], 0);
				mv(1, 1, inc[i], 0);
			end
			bus(1, `ADDR_CONTROL, 32'h00000083);
			mv(1, 2, 10'h100, 1);
		end
	endtask
	task t_misc;
		reg [9:0] p;
		begin
			bus(1, `ADDR_VELOCITY, 32'h40000000);
			bus(1, `ADDR_CONTROL, 32'h00000006);
			p = pos;
			repeat (40) @(posedge clk);
			p = pos - p;
			// a quarter step per clock: about ten steps in forty clocks, less the pipeline start
			chk("forward steps", 1, p >= 10'h008 && p <= 10'h00A);
			bus(1, `ADDR_VELOCITY, 32'hC0000000);
			repeat (5) @(posedge clk);
			p = pos;
			repeat (40) @(posedge clk);
			p = p - pos;
			chk("reverse steps", 1, p >= 10'h008 && p <= 10'h00A);
			bus(1, `ADDR_VELOCITY, 0);
			repeat (5) @(posedge clk);
			p = pos;
			repeat (20) @(posedge clk);
			chk("stopped", p, pos);
			flt <= 1'b1;
			@(posedge clk);
			flt <= 1'b0;
			repeat (3) @(posedge clk);
			chk("diagnostic_output", 1, diagnostic_output);
			en <= 1'b0;
			mode <= `MODE_STANDALONE;
			repeat (3) @(posedge clk);
			chk("diagnostic_output", 0, diagnostic_output);
			chk("stage", 0, pwr);
			host.hold_line(1'b0);
			repeat (5) @(posedge clk);
			chk("standstill", 1, sst);
			host.hold_line(1'b1);
			repeat (5) @(posedge clk);
			chk("standstill", 0, sst);
			// the bit-rate detector ignores the line in standalone, so return to serial first
			en <= 1'b1;
			mode <= `MODE_SERIAL;
			host.start_bit(1000);
			repeat (10) @(posedge clk);
			chk("locked", 1, locked);
			chk("baud", 1, baud > 16'd990 && baud < 16'd1010);
			bus(0, `ADDR_STATUS, 0);
			chk("status lock", 1, q[5]);
			chk("status baud", 1, q[31:16] > 16'd990 && q[31:16] < 16'd1010);
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d errors %0d", total_checks, errors);
			if (errors == 0 && total_checks > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	// watchdog at 30000 cycles, far beyond the fewer than two thousand cycles the tests need
	initial begin
		#300000;
		errors = errors + 1;
		$display("unexpected watchdog expected finished seen running");
		end_of_test;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_reg_res;
		t_pins;
		t_misc;
		end_of_test;
	end
endmodule
